// ==== logic/e1rbo_pkg.sv ====
// Shared constants and carrier types for the E1 receive backplane options
`default_nettype none

package e1rbo_pkg;

	// Register port geometry
	localparam int          ADDR_W        = 10;  // Address pins
	localparam int          DATA_W        = 8;   // Data pins
	localparam int          FRAMER_BIT_LO = 7;   // Framer select field low
	localparam int          FRAMER_BIT_HI = 8;   // Framer select field high
	localparam int          TEST_BIT      = 9;   // High selects test space
	localparam int          OFFS_W        = 7;   // Offset within framer

	// Register offsets within one framer
	localparam logic [6:0]  RX_OPTS_OFFS  = 7'h00; // Receive options
	localparam logic [6:0]  BP_OPTS_OFFS  = 7'h01; // Receive backplane options
	localparam logic [6:0]  DL_OPTS_OFFS  = 7'h02; // Datalink options

	// Reset values
	localparam logic [7:0]  RX_OPTS_RST   = 8'h00;
	localparam logic [7:0]  BP_OPTS_RST   = 8'h00;
	localparam logic [7:0]  DL_OPTS_RST   = 8'h00;

	// Writable masks: unused bits never store a value
	localparam logic [7:0]  RX_OPTS_MASK  = 8'hF7; // Bit 3 unused
	localparam logic [7:0]  BP_OPTS_MASK  = 8'hBF; // Bit 6 unused
	localparam logic [7:0]  DL_OPTS_MASK  = 8'hFF; // All bits used

	// Receive options fields
	localparam int          RXO_FRAME_TRUNK_COND_EN     = 0;   // frame_trunk_cond_en
	localparam int          RXO_TX_SLIP_MEASURE    = 4;   // tx_slip_measure
	localparam int          RXO_BYPASS    = 5;   // elastic_bypass

	// Receive backplane options fields
	localparam int          BPO_ALLONES   = 0;   // sig_mf_loss_allones
	localparam int          BPO_CRC_MF    = 1;   // bp_crc_mf_pulse_sel
	localparam int          BPO_SIG_MF    = 2;   // bp_sig_mf_pulse_sel
	localparam int          BPO_DUAL      = 3;   // bp_dual_rail_sel
	localparam int          BPO_OVERHEAD  = 4;   // overhead_pulse_sel
	localparam int          BPO_DMA_GATE  = 5;   // rx_dma_gate
	localparam int          BPO_CLK_SEL   = 7;   // rx_clk_out_sel

	// Datalink options fields (layout only)
	localparam int          DLO_TX_UDR_IE = 0;   // tx_hdlc_underrun_int_en
	localparam int          DLO_TX_IE     = 1;   // tx_hdlc_int_en
	localparam int          DLO_RX_EOM_IE = 2;   // rx_hdlc_eom_int_en
	localparam int          DLO_RX_IE     = 3;   // rx_hdlc_int_en
	localparam int          DLO_TX_FRAC   = 4;   // tx_fractional_sel
	localparam int          DLO_TX_DMA    = 5;   // tx_dma_sig_sel
	localparam int          DLO_RX_FRAC   = 6;   // rx_fractional_sel
	localparam int          DLO_RX_DMA    = 7;   // rx_dma_sig_sel

	// Frame geometry
	localparam int          BIT_CNT_W     = 8;   // 256 bits per frame
	localparam int          FRM_CNT_W     = 4;   // 16 frames per multiframe
	localparam logic [7:0]  FRAME_BIT1    = 8'h00; // Position of bit 1
	localparam logic [3:0]  MF_FRAME1     = 4'h0;  // Position of frame 1
	localparam logic [4:0]  TS_OVH_A      = 5'h00; // Timeslot 0
	localparam logic [4:0]  TS_OVH_B      = 5'h10; // Timeslot 16
	localparam logic [2:0]  IDLE_MSB_POS  = 3'h7;  // Bit 1 sends code MSB

	// Elastic buffer
	localparam int          FIFO_DEPTH    = 4;

	// Frame pulse modes
	typedef enum logic [1:0] {
		E1RBO_FP_FRAME     = 2'b00,
		E1RBO_FP_CRC       = 2'b01,
		E1RBO_FP_COMPOSITE = 2'b11,
		E1RBO_FP_SIG       = 2'b10
	} e1rbo_fp_mode_t;

	// One received bit with its alignment marks
	typedef struct packed {
		logic pcm;        // Single rail data
		logic sig;        // Signaling data
		logic pos;        // Positive line pulse
		logic neg;        // Negative line pulse
		logic frm_start;  // Bit 1 of a frame
		logic crc_mf;     // Frame 1 of CRC multiframe
		logic sig_mf;     // Frame 1 of signaling multiframe
		logic out_of_basic_frame;        // Out of basic frame
		logic out_of_sig_multiframe;      // Out of signaling multiframe
	} e1rbo_bit_t;

	localparam int          BIT_W         = $bits(e1rbo_bit_t);

endpackage

`default_nettype wire

// ==== logic/e1rbo_fifo.sv ====
// Small parameterised FIFO standing in for the elastic store
`default_nettype none

module e1rbo_fifo
#(
	parameter int WIDTH = 9,
	parameter int DEPTH = 4
)
(
	// Clock and reset
	input  wire logic             clk_in,
	input  wire logic             reset_in,
	// Filling side
	input  wire logic             in_valid_in,
	output var  logic             in_ready_out,
	input  wire logic [WIDTH-1:0] in_data_in,
	// Draining side
	output var  logic             out_valid_out,
	input  wire logic             out_ready_in,
	output var  logic [WIDTH-1:0] out_data_out
);

	localparam int PTR_W = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];    // Storage words
	logic [PTR_W-1:0] wr_ptr_r;         // Next write slot
	logic [PTR_W-1:0] rd_ptr_r;         // Oldest word
	logic [PTR_W:0]   count_r;          // Words held
	wire              push;
	wire              pop;

	// Honest full and empty from the word count
	assign in_ready_out  = (count_r != (PTR_W+1)'(DEPTH));
	assign out_valid_out = (count_r != '0);
	assign out_data_out  = mem_r[rd_ptr_r];
	assign push          = in_valid_in & in_ready_out;
	assign pop           = out_valid_out & out_ready_in;

	// Storage is written only on an accepted push
	always_ff @(posedge clk_in)
	begin
		if (push)
			mem_r[wr_ptr_r] <= in_data_in;
	end

	// Pointers wrap naturally since depth is a power of two
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_r <= wr_ptr_r + 1'b1;
			if (pop)
				rd_ptr_r <= rd_ptr_r + 1'b1;
			if (push & ~pop)
				count_r <= count_r + 1'b1;
			else if (pop & ~push)
				count_r <= count_r - 1'b1;
		end
	end

endmodule

`default_nettype wire

// ==== logic/e1rbo_top.sv ====
// One framer's receive backplane option registers and output formatting
`default_nettype none

// What this block does
// - Out of frame, all timeslots carry idle code
// - Whole-frame conditioning needs dual-rail and bypass clear
// - Per-timeslot conditioning honoured in single rail only; dual rail sends line pulses
// - Select zero: recovered clock out, store on backplane unless bypass or dual rail
// - Select one: both clocks from smoothed clock
// - Gating holds data request low during end-of-message
// - Dual rail outputs line pulses, else PCM/signaling
// - Signaling multiframe loss forces signaling to ones
// - Frame mode pulses at bit 1 each frame
// - CRC mode pulses every 16th frame
// - Signaling mode pulses every 16th frame
// - Composite rises at signaling, falls after CRC
// - Coincident alignments give one-bit composite pulse
// - Overhead mode high in timeslots 0 and 16
// - Pulse timed by backplane or receive output clock
// - Backplane options bit layout, bit 6 unused
// - Datalink options eight bits, reset zero
// - Reset clears all option bits
// - Unused bits ignore writes
// - Each framer owns its own copy
// - With select zero, bypass reads the store on the recovered clock; data still passes through it
module e1rbo_top
	import e1rbo_pkg::*;
#(
	parameter logic [1:0] FRAMER_INDEX = 2'h0  // Which of the four framers
)
(
	// Clock and reset
	input  wire logic              clk_in,
	input  wire logic              reset_in,
	// Microprocessor port
	input  wire logic              cpu_cs_n_in,
	input  wire logic              cpu_rd_n_in,
	input  wire logic              cpu_wr_n_in,
	input  wire logic [ADDR_W-1:0] cpu_addr_in,
	input  wire logic [DATA_W-1:0] cpu_data_in,
	output logic      [DATA_W-1:0] cpu_data_out,
	output logic                   cpu_data_oe_out,
	// Line side, from the framer core and clock sources
	input  wire logic              rec_clk_in,
	input  wire logic              smooth_clk_in,
	input  wire logic              bp_rx_clk_in,
	input  wire logic              line_pcm_in,
	input  wire logic              line_sig_in,
	input  wire logic              line_pos_in,
	input  wire logic              line_neg_in,
	input  wire logic              line_frame_start_in,
	input  wire logic              line_crc_mf_in,
	input  wire logic              line_sig_mf_in,
	input  wire logic              out_of_basic_frame_in,
	input  wire logic              out_of_sig_multiframe_in,
	// Trunk conditioning settings from neighbouring blocks
	input  wire logic [7:0]        idle_code_in,
	input  wire logic [31:0]       ts_trunk_sel_in,
	// HDLC receiver events
	input  wire logic              rx_hdlc_int_in,
	input  wire logic              rx_hdlc_eom_in,
	// Backplane outputs
	output logic                   rx_clk_out,
	output logic                   bp_rx_pcm_out,
	output logic                   bp_rx_sig_out,
	output logic                   bp_frame_pulse_out,
	output logic                   rx_hdlc_data_req_out,
	output logic                   rx_hdlc_end_msg_out,
	// Datalink option bits for the datalink blocks
	output logic      [7:0]        dl_opts_out
);

	// Index of each line input inside the synchroniser vector
	localparam int LS_REC = 11;
	localparam int LS_SMO = 10;
	localparam int LS_BPC = 9;
	localparam int LS_W   = 12;
	// Register storage
	logic [7:0]        rx_opts_r;      // Receive options
	logic [7:0]        bp_opts_r;      // Receive backplane options
	// Microprocessor pin synchronisers
	logic [2:0]        cpu_ctl_s1_r;   // First stage, read only by stage two
	logic [2:0]        cpu_ctl_s2_r;   // {cs_n, rd_n, wr_n}
	logic [2:0]        cpu_ctl_d_r;    // Previous stage-two value
	logic [ADDR_W-1:0] cpu_addr_s1_r;
	logic [ADDR_W-1:0] cpu_addr_s2_r;
	logic [DATA_W-1:0] cpu_data_s1_r;
	logic [DATA_W-1:0] cpu_data_s2_r;
	// Line pin synchronisers
	logic [LS_W-1:0]   line_s1_r;      // First stage
	logic [LS_W-1:0]   line_s2_r;      // Second stage
	logic [2:0]        clk_d_r;        // Clock levels one cycle back
	logic              out_clk_d_r;    // Store output clock one cycle back
	// Backplane side tracking
	logic [7:0]        bit_cnt_r;      // Bit within frame
	logic [3:0]        crc_frm_r;      // Frame within CRC multiframe
	logic [3:0]        sig_frm_r;      // Frame within signaling multiframe
	logic              crc_end_r;      // Last bit sent was CRC frame 1 bit 1
	// Decoded option bits
	wire               frame_trunk_cond_en     = rx_opts_r[RXO_FRAME_TRUNK_COND_EN];
	wire               bypass    = rx_opts_r[RXO_BYPASS];
	wire               clk_sel   = bp_opts_r[BPO_CLK_SEL];
	wire               dma_gate  = bp_opts_r[BPO_DMA_GATE];
	wire               ovh_sel   = bp_opts_r[BPO_OVERHEAD];
	wire               dual_sel  = bp_opts_r[BPO_DUAL];
	wire               allones   = bp_opts_r[BPO_ALLONES];
	wire e1rbo_fp_mode_t fp_mode = e1rbo_fp_mode_t'(
		{bp_opts_r[BPO_SIG_MF], bp_opts_r[BPO_CRC_MF]});
	// Register port decode; the framer field keeps copies apart
	wire               cs_now    = ~cpu_ctl_s2_r[2];
	wire               rd_now    = ~cpu_ctl_s2_r[1];
	wire               wr_end    = ~cpu_ctl_d_r[0] & cpu_ctl_s2_r[0]
	                               & ~cpu_ctl_d_r[2];
	wire               frm_hit   = ~cpu_addr_s2_r[TEST_BIT] &
		(cpu_addr_s2_r[FRAMER_BIT_HI:FRAMER_BIT_LO] == FRAMER_INDEX);
	wire [6:0]         offs      = cpu_addr_s2_r[OFFS_W-1:0];
	wire               hit_rx    = frm_hit & (offs == RX_OPTS_OFFS);
	wire               hit_bp    = frm_hit & (offs == BP_OPTS_OFFS);
	wire               hit_dl    = frm_hit & (offs == DL_OPTS_OFFS);
	wire               any_hit   = hit_rx | hit_bp | hit_dl;
	wire [7:0]         rd_sel    = hit_rx ? (rx_opts_r & RX_OPTS_MASK) :
	                               hit_bp ? (bp_opts_r & BP_OPTS_MASK) :
	                               hit_dl ? dl_opts_out : 8'h00;
	// Clock sources and edge events after synchronising
	wire               rec_lvl   = line_s2_r[LS_REC];
	wire               smo_lvl   = line_s2_r[LS_SMO];
	wire               bpc_lvl   = line_s2_r[LS_BPC];
	wire               rec_rise  = rec_lvl & ~clk_d_r[2];
	// Store output clock: smoothed if selected, else recovered if bypassed or dual rail, else backplane
	// Dual rail follows the receive clock output, not the backplane
	wire               out_clk_lvl = clk_sel ? smo_lvl :
	                                 bypass | dual_sel ? rec_lvl :
	                                           bpc_lvl;
	wire               out_fall  = out_clk_d_r & ~out_clk_lvl;

	// Captured bit on the line side
	e1rbo_bit_t        line_bit;
	assign line_bit = '{
		pcm:       line_s2_r[8],
		sig:       line_s2_r[7],
		pos:       line_s2_r[6],
		neg:       line_s2_r[5],
		frm_start: line_s2_r[4],
		crc_mf:    line_s2_r[3],
		sig_mf:    line_s2_r[2],
		out_of_basic_frame:       line_s2_r[1],
		out_of_sig_multiframe:     line_s2_r[0]
	};

	// Elastic buffer between recovered and output timing
	wire               fifo_out_valid;
	e1rbo_bit_t        fifo_word;
	wire               pop = out_fall & fifo_out_valid;

	e1rbo_fifo #(
		.WIDTH (BIT_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_in        (clk_in),
		.reset_in      (reset_in),
		.in_valid_in   (rec_rise),
		.in_ready_out  (),  // A full store drops the bit: a slip
		.in_data_in    (line_bit),
		.out_valid_out (fifo_out_valid),
		.out_ready_in  (out_fall),
		.out_data_out  (fifo_word)
	);

	// Position of the bit now leaving the store
	wire [7:0]         bit_nxt   = fifo_word.frm_start ? FRAME_BIT1 :
	                               bit_cnt_r + 8'h01;
	wire               frm_new   = (bit_nxt == FRAME_BIT1);
	wire [3:0]         crc_nxt   = ~frm_new ? crc_frm_r :
	                               fifo_word.crc_mf ? MF_FRAME1 :
	                               crc_frm_r + 4'h1;
	wire [3:0]         sig_nxt   = ~frm_new ? sig_frm_r :
	                               fifo_word.sig_mf ? MF_FRAME1 :
	                               sig_frm_r + 4'h1;
	wire [4:0]         ts_nxt    = bit_nxt[7:3];
	wire               crc_start = frm_new & (crc_nxt == MF_FRAME1);
	wire               sig_start = frm_new & (sig_nxt == MF_FRAME1);

	// Trunk conditioning: whole frame only in single rail with bypass clear
	wire               whole_trk = frame_trunk_cond_en & ~dual_sel & ~bypass;
	wire               trk_now   = (whole_trk & fifo_word.out_of_basic_frame) |
	                               ts_trunk_sel_in[ts_nxt];
	wire               idle_bit  = idle_code_in[IDLE_MSB_POS - bit_nxt[2:0]];
	wire               pcm_nxt   = dual_sel ? fifo_word.pos :
	                               trk_now  ? idle_bit :
	                                          fifo_word.pcm;
	wire               sig_bit   = dual_sel ? fifo_word.neg :
	                               (allones & fifo_word.out_of_sig_multiframe) ? 1'b1 :
	                                          fifo_word.sig;

	// Frame pulse for the bit now leaving
	logic              fp_nxt;
	always_comb
	begin
		fp_nxt = 1'b0;
		if (ovh_sel)
			fp_nxt = (ts_nxt == TS_OVH_A) | (ts_nxt == TS_OVH_B);
		else
		begin
			case (fp_mode)
				E1RBO_FP_FRAME:     fp_nxt = frm_new;
				E1RBO_FP_CRC:       fp_nxt = crc_start;
				E1RBO_FP_SIG:       fp_nxt = sig_start;
				// Set wins so coincident marks give one bit high
				E1RBO_FP_COMPOSITE: fp_nxt = sig_start ? 1'b1 :
				                    crc_end_r ? 1'b0 :
				                    bp_frame_pulse_out;
				default:            fp_nxt = 1'b0;
			endcase
		end
	end

	// Pin synchronisers; stage one feeds nothing but stage two
	always_ff @(posedge clk_in)
	begin
		cpu_ctl_s1_r  <= {cpu_cs_n_in, cpu_rd_n_in, cpu_wr_n_in};
		cpu_ctl_s2_r  <= cpu_ctl_s1_r;
		cpu_addr_s1_r <= cpu_addr_in;
		cpu_addr_s2_r <= cpu_addr_s1_r;
		cpu_data_s1_r <= cpu_data_in;
		cpu_data_s2_r <= cpu_data_s1_r;
		line_s1_r     <= {rec_clk_in, smooth_clk_in, bp_rx_clk_in,
		                  line_pcm_in, line_sig_in, line_pos_in,
		                  line_neg_in, line_frame_start_in, line_crc_mf_in,
		                  line_sig_mf_in, out_of_basic_frame_in,
		                  out_of_sig_multiframe_in};
		line_s2_r     <= line_s1_r;
	end

	// Edge history; strobes idle high so reset parks them there
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			cpu_ctl_d_r <= 3'h7;
			clk_d_r     <= 3'h0;
			out_clk_d_r <= 1'b0;
		end
		else
		begin
			cpu_ctl_d_r <= cpu_ctl_s2_r;
			clk_d_r     <= line_s2_r[LS_REC:LS_BPC];
			out_clk_d_r <= out_clk_lvl;
		end
	end

	// Option registers, written at the trailing edge of the write strobe
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			rx_opts_r   <= RX_OPTS_RST;
			bp_opts_r   <= BP_OPTS_RST;
			dl_opts_out <= DL_OPTS_RST;
		end
		else if (wr_end)
		begin
			// Masks keep unused bits at zero whatever is written
			if (hit_rx)
				rx_opts_r   <= cpu_data_s2_r & RX_OPTS_MASK;
			if (hit_bp)
				bp_opts_r   <= cpu_data_s2_r & BP_OPTS_MASK;
			if (hit_dl)
				dl_opts_out <= cpu_data_s2_r & DL_OPTS_MASK;
		end
	end

	// Read data and bus drive while this framer is read
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			cpu_data_out    <= 8'h00;
			cpu_data_oe_out <= 1'b0;
		end
		else
		begin
			cpu_data_out    <= rd_sel;
			cpu_data_oe_out <= cs_now & rd_now & any_hit;
		end
	end

	// Receive clock output; slip measurement is left to software
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
			rx_clk_out <= 1'b0;
		else
			rx_clk_out <= clk_sel ? smo_lvl : rec_lvl;
	end

	// HDLC DMA outputs, gated when asked
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			rx_hdlc_data_req_out <= 1'b0;
			rx_hdlc_end_msg_out  <= 1'b0;
		end
		else
		begin
			rx_hdlc_data_req_out <= rx_hdlc_int_in &
			                        ~(dma_gate & rx_hdlc_eom_in);
			rx_hdlc_end_msg_out  <= rx_hdlc_eom_in;
		end
	end

	// Backplane data side; an empty store holds the last bit out
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			bit_cnt_r          <= FRAME_BIT1;
			crc_frm_r          <= MF_FRAME1;
			sig_frm_r          <= MF_FRAME1;
			crc_end_r          <= 1'b0;
			bp_rx_pcm_out      <= 1'b0;
			bp_rx_sig_out      <= 1'b0;
			bp_frame_pulse_out <= 1'b0;
		end
		else if (pop)
		begin
			bit_cnt_r          <= bit_nxt;
			crc_frm_r          <= crc_nxt;
			sig_frm_r          <= sig_nxt;
			crc_end_r          <= crc_start;
			bp_rx_pcm_out      <= pcm_nxt;
			bp_rx_sig_out      <= sig_bit;
			bp_frame_pulse_out <= fp_nxt;
		end
	end

endmodule

`default_nettype wire

// ==== tb/e1rbo_asserts.sv ====
// Port checker for one framer's receive backplane options block
`default_nettype none

module e1rbo_asserts
(
	// Clock and reset
	input  wire logic       clk_in,
	input  wire logic       reset_in,
	// Register port
	input  wire logic       cpu_cs_n_in,
	input  wire logic       cpu_rd_n_in,
	input  wire logic       cpu_wr_n_in,
	input  wire logic       cpu_data_oe_out,
	input  wire logic [7:0] dl_opts_out,
	// HDLC and backplane
	input  wire logic       rx_hdlc_int_in,
	input  wire logic       rx_hdlc_eom_in,
	input  wire logic       rx_hdlc_data_req_out,
	input  wire logic       rx_hdlc_end_msg_out,
	input  wire logic       bp_frame_pulse_out
);
	timeunit 1ns;
	timeprecision 100ps;
	// One domain, so clock and reset are given once
	default clocking @(posedge clk_in); endclocking
	default disable iff (reset_in);

	a_eom_copy: assert property (!$past(reset_in) |->
		rx_hdlc_end_msg_out == $past(rx_hdlc_eom_in))
		else $error("end of message not copied");
	a_req_needs_int: assert property (rx_hdlc_data_req_out |->
		$past(rx_hdlc_int_in))
		else $error("data request without event");
	// Without end of message the gate must never block
	a_req_ungated: assert property (!$past(reset_in)
		&& $past(rx_hdlc_int_in) && !$past(rx_hdlc_eom_in)
		|-> rx_hdlc_data_req_out)
		else $error("data request blocked");
	a_reset_quiet: assert property (disable iff (1'b0) reset_in |=>
		!bp_frame_pulse_out && !cpu_data_oe_out && dl_opts_out == 8'h00)
		else $error("outputs not cleared by reset");
	a_oe_after_read: assert property ($rose(cpu_data_oe_out) |->
		!$past(cpu_rd_n_in, 2) && !$past(cpu_cs_n_in, 2))
		else $error("data driven without a read");
	a_oe_rd_drop: assert property (cpu_rd_n_in [*6] |->
		!cpu_data_oe_out)
		else $error("data still driven after read");
	a_oe_cs_drop: assert property (cpu_cs_n_in [*6] |->
		!cpu_data_oe_out)
		else $error("data driven while deselected");
	// A long low strobe means the last write landed long ago
	a_dl_stable: assert property ((!cpu_wr_n_in) [*8] |->
		$stable(dl_opts_out))
		else $error("datalink options changed without write");

	c_read: cover property ($rose(cpu_data_oe_out));
	c_pulse: cover property ($rose(bp_frame_pulse_out));
	c_gated: cover property (rx_hdlc_int_in && rx_hdlc_eom_in
		&& !rx_hdlc_data_req_out);
endmodule

bind e1rbo_top e1rbo_asserts u_chk (.clk_in(clk_in), .reset_in(reset_in),
	.cpu_cs_n_in(cpu_cs_n_in), .cpu_rd_n_in(cpu_rd_n_in),
	.cpu_wr_n_in(cpu_wr_n_in), .cpu_data_oe_out(cpu_data_oe_out),
	.dl_opts_out(dl_opts_out), .rx_hdlc_int_in(rx_hdlc_int_in),
	.rx_hdlc_eom_in(rx_hdlc_eom_in),
	.rx_hdlc_data_req_out(rx_hdlc_data_req_out),
	.rx_hdlc_end_msg_out(rx_hdlc_end_msg_out),
	.bp_frame_pulse_out(bp_frame_pulse_out));

`default_nettype wire

// ==== tb/e1rbo_line_model.sv ====
// Behavioural line source: clocks and alignment marks
`default_nettype none

module e1rbo_line_model
(
	// Clocks toward the block
	output var  logic rec_clk_out,
	output var  logic smooth_clk_out,
	output var  logic bp_clk_out,
	// Alignment marks, changed on the falling line edge
	output wire logic frm_out,
	output wire logic crc_out,
	output wire logic smf_out
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] bit_r = 8'h00;  // Bit within frame
	logic [3:0] frm_r = 4'h0;   // Frame within multiframe

	// Line clock runs free; smoothed clock is slower so a swap shows
	initial
	begin
		rec_clk_out = 1'b0;
		smooth_clk_out = 1'b0;
		bp_clk_out = 1'b0;
		fork
			forever #40 rec_clk_out = ~rec_clk_out;
			forever #60 smooth_clk_out = ~smooth_clk_out;
			#20 forever #40 bp_clk_out = ~bp_clk_out;
		join
	end

	// Count 256 bits a frame and 16 frames a multiframe
	always @(negedge rec_clk_out)
	begin
		bit_r <= bit_r + 8'h01;
		if (bit_r == 8'hFF)
			frm_r <= frm_r + 4'h1;
	end

	// Both multiframes coincide, so composite gives one bit
	assign frm_out = (bit_r == 8'h00);
	assign crc_out = frm_out && (frm_r == 4'h0);
	assign smf_out = frm_out && (frm_r == 4'h0);
endmodule

`default_nettype wire

// ==== tb/e1rbo_top_test.sv ====
// Self-checking bench for one framer's backplane options block
`default_nettype none

module e1rbo_top_test;
	import e1rbo_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_in = 1'b0;            // System clock
	logic reset_in = 1'b1;          // Synchronous reset
	logic cs_n = 1'b1;              // Register strobes, idle high
	logic rd_n = 1'b1;
	logic wr_n = 1'b1;
	logic [9:0] addr = 10'h000;
	logic [7:0] wdata = 8'h00;
	logic [7:0] idle = 8'hFF;       // Idle code, all ones shows clearly
	logic [31:0] ts_sel = 32'h0;    // Per-timeslot conditioning
	logic basic_lost = 1'b1;        // Framer out of basic frame
	logic sigmf_lost = 1'b0;        // Framer out of signaling multiframe
	logic hint = 1'b0;              // HDLC events
	logic heom = 1'b0;
	wire rec, smo, bpc, fs, cmf, smf;
	wire [7:0] rdata;
	wire [7:0] dl;
	wire oe, rxck, opcm, osig, fp, req, eomo;
	int n_fail = 0;
	int checks_done = 0;
	int n_pcm, n_sig, n_fpr, n_fph, n_ck;
	logic [7:0] rv;

	// Line source stands where the framer core and clocks would be
	e1rbo_line_model u_line (.rec_clk_out(rec), .smooth_clk_out(smo),
		.bp_clk_out(bpc), .frm_out(fs), .crc_out(cmf), .smf_out(smf));

	e1rbo_top DUT (.clk_in(clk_in), .reset_in(reset_in),
		.cpu_cs_n_in(cs_n), .cpu_rd_n_in(rd_n), .cpu_wr_n_in(wr_n),
		.cpu_addr_in(addr), .cpu_data_in(wdata), .cpu_data_out(rdata),
		.cpu_data_oe_out(oe), .rec_clk_in(rec), .smooth_clk_in(smo),
		.bp_rx_clk_in(bpc), .line_pcm_in(1'b0), .line_sig_in(1'b0),
		.line_pos_in(1'b0), .line_neg_in(1'b1), .line_frame_start_in(fs),
		.line_crc_mf_in(cmf), .line_sig_mf_in(smf),
		.out_of_basic_frame_in(basic_lost),
		.out_of_sig_multiframe_in(sigmf_lost), .idle_code_in(idle),
		.ts_trunk_sel_in(ts_sel), .rx_hdlc_int_in(hint),
		.rx_hdlc_eom_in(heom), .rx_clk_out(rxck), .bp_rx_pcm_out(opcm),
		.bp_rx_sig_out(osig), .bp_frame_pulse_out(fp),
		.rx_hdlc_data_req_out(req), .rx_hdlc_end_msg_out(eomo),
		.dl_opts_out(dl));

	// System clock at 100 MHz
	initial
	begin
		forever #5 clk_in = ~clk_in;
	end

	// Compare one value and count it
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Verdict and end of run
	task automatic complete_run();
		if (n_fail == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Write strobe held long; the write lands after its release while select stays low
	task automatic reg_wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr <= a;
		wdata <= d;
		cs_n <= 1'b0;
		wr_n <= 1'b0;
		repeat (8) @(posedge clk_in);
		wr_n <= 1'b1;
		repeat (2) @(posedge clk_in);
		cs_n <= 1'b1;
		repeat (8) @(posedge clk_in);
	endtask

	// Read; a mapped place that never answers ends the run
	task automatic reg_rd(input logic [9:0] a, input logic want,
		output logic [7:0] d);
		logic seen;
		seen = 1'b0;
		@(posedge clk_in);
		addr <= a;
		cs_n <= 1'b0;
		rd_n <= 1'b0;
		for (int i = 0; i < 8 && !seen; i++)
		begin
			@(negedge clk_in);
			seen = (oe === 1'b1);
		end
		d = rdata;
		check(seen, want);
		if (want && !seen)
			complete_run();
		@(posedge clk_in);
		cs_n <= 1'b1;
		rd_n <= 1'b1;
		repeat (8) @(posedge clk_in);
	endtask

	// Count output activity over a window of clock cycles
	task automatic watch(input int cyc);
		logic pf, pc;
		n_pcm = 0;
		n_sig = 0;
		n_fpr = 0;
		n_fph = 0;
		n_ck = 0;
		@(negedge clk_in);
		pf = fp;
		pc = rxck;
		repeat (cyc)
		begin
			@(negedge clk_in);
			n_pcm += (opcm === 1'b1);
			n_sig += (osig === 1'b1);
			n_fph += (fp === 1'b1);
			n_fpr += (fp === 1'b1 && pf === 1'b0);
			n_ck += (rxck === 1'b1 && pc === 1'b0);
			pf = fp;
			pc = rxck;
		end
		@(posedge clk_in);
	endtask

	// Set both option registers, let the store refill, then watch
	task automatic cfg(input logic [7:0] rx, input logic [7:0] bp,
		input int cyc);
		reg_wr(10'h000, rx);
		reg_wr(10'h001, bp);
		repeat (100) @(posedge clk_in);
		watch(cyc);
	endtask

	// Reset values, layout, refused places and a second reset
	task automatic t_regs();
		reg_rd(10'h001, 1'b1, rv);
		check(rv, 8'h00);
		reg_rd(10'h002, 1'b1, rv);
		check(rv, 8'h00);
		reg_wr(10'h001, 8'hFF);
		reg_rd(10'h001, 1'b1, rv);
		check(rv & 8'hBF, 8'hBF);
		reg_wr(10'h002, 8'hA5);
		reg_rd(10'h002, 1'b1, rv);
		check(rv, 8'hA5);
		check(dl, 8'hA5);
		reg_wr(10'h081, 8'h00);
		reg_rd(10'h001, 1'b1, rv);
		check(rv & 8'hBF, 8'hBF);
		reg_rd(10'h081, 1'b0, rv);
		reg_rd(10'h201, 1'b0, rv);
		reg_rd(10'h003, 1'b0, rv);
		@(posedge clk_in);
		reset_in <= 1'b1;
		repeat (4) @(posedge clk_in);
		reset_in <= 1'b0;
		reg_rd(10'h001, 1'b1, rv);
		check(rv, 8'h00);
		check(dl, 8'h00);
	endtask

	// Data request gated by end of message only when asked
	task automatic t_hdlc();
		reg_wr(10'h001, 8'h20);
		hint <= 1'b1;
		heom <= 1'b1;
		repeat (3) @(negedge clk_in);
		check(req, 1'b0);
		check(eomo, 1'b1);
		@(posedge clk_in);
		heom <= 1'b0;
		repeat (2) @(negedge clk_in);
		check(req, 1'b1);
		@(posedge clk_in);
		heom <= 1'b1;
		reg_wr(10'h001, 8'h00);
		@(negedge clk_in);
		check(req, 1'b1);
		@(posedge clk_in);
		hint <= 1'b0;
		heom <= 1'b0;
	endtask

	// Line sends zeros and a negative rail of ones
	task automatic t_rails();
		cfg(8'h00, 8'h00, 400);
		check(n_pcm, 0);
		cfg(8'h01, 8'h00, 400);
		check(n_pcm, 400);
		cfg(8'h21, 8'h00, 400);
		check(n_pcm, 0);
		cfg(8'h01, 8'h08, 400);
		check(n_pcm, 0);
		check(n_sig, 400);
		ts_sel <= 32'hFFFFFFFF;
		cfg(8'h00, 8'h00, 400);
		check(n_pcm, 400);
		ts_sel <= 32'h0;
		sigmf_lost <= 1'b1;
		cfg(8'h00, 8'h01, 400);
		check(n_sig, 400);
		cfg(8'h00, 8'h00, 400);
		check(n_sig, 0);
		sigmf_lost <= 1'b0;
		basic_lost <= 1'b0;
	endtask

	// Receive clock output follows the recovered clock, then the smoothed clock when chosen
	task automatic t_clk();
		cfg(8'h00, 8'h00, 2400);
		check(n_ck >= 299 && n_ck <= 301, 1'b1);
		cfg(8'h00, 8'h80, 2400);
		check(n_ck >= 199 && n_ck <= 201, 1'b1);
	endtask

	// Frame pulse modes over whole frames and multiframes
	task automatic t_pulse();
		cfg(8'h00, 8'h00, 4096);
		check(n_fpr, 2);
		check(n_fph, 16);
		cfg(8'h00, 8'h16, 4096);
		check(n_fpr, 4);
		check(n_fph, 256);
		cfg(8'h00, 8'h02, 32768);
		check(n_fpr, 1);
		check(n_fph, 8);
		cfg(8'h00, 8'h06, 32768);
		check(n_fpr, 1);
		check(n_fph, 8);
	endtask

	// Main sequence
	initial
	begin
		repeat (4) @(posedge clk_in);
		reset_in <= 1'b0;
		t_regs();
		t_hdlc();
		t_rails();
		t_clk();
		t_pulse();
		complete_run();
	end
endmodule

`default_nettype wire
